// ==== core/ppfc_pkg.sv ====
package ppfc_pkg;

  localparam logic [3:0] PPFC_ADR_P4_DATA    = 4'h0;
  localparam logic [3:0] PPFC_ADR_P5_DATA    = 4'h1;
  localparam logic [3:0] PPFC_ADR_P6_DATA    = 4'h2;
  localparam logic [3:0] PPFC_ADR_P7_DATA    = 4'h3;
  localparam logic [3:0] PPFC_ADR_P8_DATA    = 4'h4;
  localparam logic [3:0] PPFC_ADR_P9_DATA    = 4'h5;
  localparam logic [3:0] PPFC_ADR_P4_DIR     = 4'h6;
  localparam logic [3:0] PPFC_ADR_P5_DIR     = 4'h7;
  localparam logic [3:0] PPFC_ADR_P6_DIR     = 4'h8;
  localparam logic [3:0] PPFC_ADR_P7_DIR     = 4'h9;
  localparam logic [3:0] PPFC_ADR_P8_DIR     = 4'hA;
  localparam logic [3:0] PPFC_ADR_P9_DIR     = 4'hB;
  localparam logic [3:0] PPFC_ADR_ANA_GROUP  = 4'hC;
  localparam logic [3:0] PPFC_ADR_EXTRA_CTRL = 4'hD;
  localparam logic [3:0] PPFC_ADR_MODE_A     = 4'hE;
  localparam logic [3:0] PPFC_ADR_PIN_LEVEL  = 4'hF;

  localparam int PPFC_NPORT      = 6;
  localparam int PPFC_ADR_LSB    = 2;
  localparam int PPFC_DIR_BASE   = 6;
  localparam int PPFC_P4         = 0;
  localparam int PPFC_P5         = 1;
  localparam int PPFC_P7         = 3;
  localparam int PPFC_BIT_P4_ANA = 1;
  localparam int PPFC_BIT_P5_ANA = 2;
  localparam int PPFC_BIT_SO_OD  = 2;
  localparam int PPFC_BIT_PU_EN  = 3;
  localparam int PPFC_BIT_SO_SEL = 0;

  localparam logic [3:0] PPFC_DATA_RST  = 4'hF;
  localparam logic [3:0] PPFC_DIR_RST   = 4'h0;
  localparam logic [2:0] PPFC_ANA_RST   = 3'h0;
  localparam logic [3:0] PPFC_CTRL_RST  = 4'h0;
  localparam logic [3:0] PPFC_P7_MASK   = 4'h7;
  localparam logic [3:0] PPFC_NIB_ZERO  = 4'h0;
  localparam logic [31:0] PPFC_WORD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [3:0] pmos_on;
    logic [3:0] nmos_on;
    logic [3:0] pullup_on;
  } ppfc_drive_type;

endpackage

// ==== core/ppfc_pin_cell.sv ====
`timescale 1ns/1ps
module ppfc_pin_cell
  import ppfc_pkg::*;
(
  input  wire logic           analog_i,
  input  wire logic           pu_en_i,
  input  wire logic           od_i,
  input  wire logic [3:0]     dir_i,
  input  wire logic [3:0]     data_i,
  output ppfc_drive_type      drive_o
);

  wire logic [3:0] port_out = analog_i ? PPFC_NIB_ZERO : dir_i;

  assign drive_o.nmos_on   = port_out & ~data_i;
  assign drive_o.pmos_on   = od_i ? PPFC_NIB_ZERO : (port_out & data_i);
  // Pull-up ignores the analog select, so software must clear data first.
  assign drive_o.pullup_on = pu_en_i ? data_i : PPFC_NIB_ZERO;

endmodule

// ==== core/ppfc_top.sv ====
`timescale 1ns/1ps
// Functional notes
// - Port four group select high makes all four pins analog inputs four to seven.
// - Port five group select high makes all four pins analog inputs eight to eleven.
// - Port six pins: direction bit 0 input, 1 output.
// - Port seven bits 0 to 2: direction bit 0 input, 1 output.
// - Port eight pins: direction bit 0 input, 1 output.
// - Port nine pins: direction bit 0 input, 1 output.
// - Serial output open-drain bit makes the serial data pin drive only low.
// - Selecting analog never switches off a pull-up that is enabled with data 1.
// - Reset sets every output data bit to 1.
// - Direction 1 drives data through NMOS or PMOS; direction 0 both off.
// - Pull-up on exactly when pull-up enable and data bit are both 1.
// - Analog selection turns both drivers off regardless of direction and data.
// - Open-drain pins: direction 0 float, data 0 low, data 1 float; port pins here are push-pull (od_i tied to 0).
// - Group select register is write-only and resets to 0.
module ppfc_top
  import ppfc_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [5:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [23:0]           pin_i,
  output logic      [23:0]           pin_o,
  output logic      [23:0]           pin_oe_o,
  output logic      [23:0]           pullup_o,
  output logic      [7:0]            analog_en_o,
  input  wire logic                  so_func_i,
  input  wire logic                  so_pin_i,
  output logic                       so_pin_o,
  output logic                       so_pin_oe_o,
  output logic                       so_sel_o
);

  logic [3:0]  data_r [PPFC_NPORT];
  logic [3:0]  dir_r  [PPFC_NPORT];
  logic [2:0]  ana_r;
  logic [3:0]  ctrl_r;
  logic [3:0]  mode_r;
  logic [23:0] level_r;
  logic        ack_r;
  logic [31:0] rdat_nxt;

  ppfc_drive_type drv [PPFC_NPORT];
  logic [23:0] pin_nxt;
  logic [23:0] oe_nxt;
  logic [23:0] pu_nxt;

  function automatic logic [3:0] ppfc_mask_fn(input int idx);
    ppfc_mask_fn = (idx == PPFC_P7) ? PPFC_P7_MASK : PPFC_DATA_RST;
  endfunction

  wire logic [3:0] reg_idx  = wb_adr_i[5:2];
  wire logic       req      = wb_cyc_i & wb_stb_i & ~ack_r;
  wire logic       wr_en    = req & wb_we_i & wb_sel_i[0];
  wire logic       pu_en    = ctrl_r[PPFC_BIT_PU_EN];
  wire logic       so_od    = ctrl_r[PPFC_BIT_SO_OD];
  wire logic       p4_ana   = ana_r[PPFC_BIT_P4_ANA];
  wire logic       p5_ana   = ana_r[PPFC_BIT_P5_ANA];

  genvar g;
  generate
    for (g = 0; g < PPFC_NPORT; g = g + 1) begin : g_port
      wire logic analog = (g == PPFC_P4) ? p4_ana : ((g == PPFC_P5) ? p5_ana : 1'b0);
      ppfc_pin_cell u_cell (
        .analog_i (analog),
        .pu_en_i  (pu_en),
        .od_i     (1'b0),
        .dir_i    (dir_r[g] & ppfc_mask_fn(g)),
        .data_i   (data_r[g] & ppfc_mask_fn(g)),
        .drive_o  (drv[g])
      );
      // Push-pull pads: pin level follows PMOS, enable when either driver is on.
      assign pin_nxt[4*g+3:4*g] = drv[g].pmos_on;
      assign oe_nxt[4*g+3:4*g]  = drv[g].pmos_on | drv[g].nmos_on;
      assign pu_nxt[4*g+3:4*g]  = drv[g].pullup_on;
    end
  endgenerate

  // Serial data pin: open drain drives only low, both for port and serial use.
  wire logic so_level = mode_r[PPFC_BIT_SO_SEL] ? so_func_i : 1'b1;
  wire logic so_oe    = so_od ? ~so_level : 1'b1;

  always_comb begin
    rdat_nxt = PPFC_WORD_ZERO;
    if (reg_idx < PPFC_DIR_BASE) begin
      rdat_nxt[3:0] = data_r[reg_idx[2:0]];
    end else if (reg_idx < PPFC_ADR_ANA_GROUP) begin
      rdat_nxt[3:0] = dir_r[reg_idx[2:0] - 3'(PPFC_DIR_BASE)];
    end else if (reg_idx == PPFC_ADR_EXTRA_CTRL) begin
      rdat_nxt[3:0] = ctrl_r;
    end else if (reg_idx == PPFC_ADR_MODE_A) begin
      rdat_nxt[3:0] = mode_r;
    end else if (reg_idx == PPFC_ADR_PIN_LEVEL) begin
      rdat_nxt[23:0] = level_r;
    end
    // Group select reads as zero: write-only.
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PPFC_NPORT; i++) begin
        data_r[i] <= PPFC_DATA_RST;
        dir_r[i]  <= PPFC_DIR_RST;
      end
      ana_r  <= PPFC_ANA_RST;
      ctrl_r <= PPFC_CTRL_RST;
      mode_r <= PPFC_CTRL_RST;
    end else if (wr_en) begin
      if (reg_idx < PPFC_DIR_BASE) begin
        data_r[reg_idx[2:0]] <= wb_dat_i[3:0];
      end else if (reg_idx < PPFC_ADR_ANA_GROUP) begin
        dir_r[reg_idx[2:0] - 3'(PPFC_DIR_BASE)] <= wb_dat_i[3:0];
      end else if (reg_idx == PPFC_ADR_ANA_GROUP) begin
        ana_r <= wb_dat_i[2:0];
      end else if (reg_idx == PPFC_ADR_EXTRA_CTRL) begin
        ctrl_r <= wb_dat_i[3:0];
      end else if (reg_idx == PPFC_ADR_MODE_A) begin
        mode_r <= wb_dat_i[3:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r       <= 1'b0;
      wb_dat_o    <= PPFC_WORD_ZERO;
      pin_o       <= 24'h000000;
      pin_oe_o    <= 24'h000000;
      pullup_o    <= 24'h000000;
      analog_en_o <= 8'h00;
      so_pin_o    <= 1'b0;
      so_pin_oe_o <= 1'b0;
      so_sel_o    <= 1'b0;
      level_r     <= 24'h000000;
    end else begin
      ack_r       <= req;
      wb_dat_o    <= req ? rdat_nxt : PPFC_WORD_ZERO;
      pin_o       <= pin_nxt;
      pin_oe_o    <= oe_nxt;
      pullup_o    <= pu_nxt;
      analog_en_o <= {{4{p5_ana}}, {4{p4_ana}}};
      so_pin_o    <= so_od ? 1'b0 : so_level;
      so_pin_oe_o <= so_oe;
      so_sel_o    <= mode_r[PPFC_BIT_SO_SEL];
      level_r     <= pin_i;
    end
  end

  assign wb_ack_o = ack_r;

  // The serial pin input is kept for a port-mode read path; nothing samples it yet.
  wire logic unused_so = so_pin_i;

endmodule

// ==== sim/ppfc_checker.sv ====
`timescale 1ns/1ps
module ppfc_checker
  import ppfc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [23:0] pin_o,
  input wire logic [23:0] pin_oe_o,
  input wire logic [23:0] pullup_o,
  input wire logic [7:0]  analog_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  req_ack_a: assert property (req_s |=> ack_s) else $error("request without one ack pulse");
  idle_no_ack_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
  group_whole_a: assert property (analog_en_o[3:0] inside {4'h0, 4'hF}
    && analog_en_o[7:4] inside {4'h0, 4'hF}) else $error("analog group split");
  analog_float_a: assert property ((pin_oe_o[7:0] & analog_en_o) == 8'h00) else $error("analog pin driven");
  pmos_oe_a: assert property ((pin_o & ~pin_oe_o) == 24'h000000) else $error("level high without drive");
  p7_top_off_a: assert property (!pin_oe_o[15] && !pullup_o[15]) else $error("port seven bit three active");
  group_read_zero_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i[5:2] == PPFC_ADR_ANA_GROUP)
    |-> wb_dat_o == PPFC_WORD_ZERO) else $error("group select readable");
  group_write_only_a: assert property (!$stable(analog_en_o) |-> $past(wb_we_i && wb_ack_o))
    else $error("analog select moved without write");
endmodule
bind ppfc_top ppfc_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_o(pin_o),
  .pin_oe_o(pin_oe_o), .pullup_o(pullup_o), .analog_en_o(analog_en_o));

// ==== sim/ppfc_pin_model.sv ====
`timescale 1ns/1ps
module ppfc_pin_model (
  input  wire logic        clk_i,
  input  wire logic [23:0] pin_o,
  input  wire logic [23:0] pin_oe_o,
  input  wire logic [23:0] pullup_o,
  input  wire logic        so_pin_o,
  input  wire logic        so_pin_oe_o,
  output logic      [23:0] pin_i,
  output logic             so_pin_i
);
  // Undriven pads without a pull-up toggle every cycle so a stale level can never pass for a real one.
  logic [23:0] float_r = 24'hA5A5A5;
  always_ff @(posedge clk_i) float_r <= ~float_r;
  assign pin_i    = (pin_oe_o & pin_o) | (~pin_oe_o & (pullup_o | float_r));
  assign so_pin_i = so_pin_oe_o ? so_pin_o : float_r[0];
endmodule

// ==== sim/port_pin_function_control_test.sv ====
`timescale 1ns/1ps
module port_pin_function_control_test;
  import ppfc_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, so_func = 0;
  logic [5:0]  adr = 6'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rd, wb_dat_o;
  logic        wb_ack_o, so_pin_i, so_pin_o, so_pin_oe_o, so_sel_o;
  logic [23:0] pin_i, pin_o, pin_oe_o, pullup_o;
  logic [7:0]  analog_en_o;
  int          regs[16], miscompares = 0, n_tests = 0;
  always #10 clk_i = ~clk_i;
  ppfc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pullup_o(pullup_o), .analog_en_o(analog_en_o), .so_func_i(so_func),
    .so_pin_i(so_pin_i), .so_pin_o(so_pin_o), .so_pin_oe_o(so_pin_oe_o), .so_sel_o(so_sel_o));
  ppfc_pin_model u_pins (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_o(pullup_o),
    .so_pin_o(so_pin_o), .so_pin_oe_o(so_pin_oe_o), .pin_i(pin_i), .so_pin_i(so_pin_i));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    int n;
    n = 0;
    m = (a == 3 || a == 9) ? 32'hFFFFFFF7 : 32'hFFFFFFFF;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, 2'b00, d, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    {cyc, stb} <= 2'b00;
    chk("ack", 32'h1, {31'h0, wb_ack_o});
    if (w && s[0] && a != 15) regs[a] = d & (a == 12 ? 7 : 15);
    if (!w && a != 15) chk("rdata", (a == 12 ? 0 : regs[a]) & m, rd & m);
  endtask
  task automatic check();
    logic [23:0] eo, eoe, epu;
    logic        lv, od;
    int          p, b, an;
    @(posedge clk_i);
    for (int i = 0; i < 24; i++) begin
      p = i / 4;
      b = i % 4;
      an = (p == 0 && regs[12][1]) || (p == 1 && regs[12][2]);
      epu[i] = regs[13][3] && regs[p][b] && i != 15;
      eoe[i] = !an && regs[p + 6][b] && i != 15;
      eo[i] = eoe[i] && regs[p][b];
    end
    lv = regs[14][0] ? so_func : 1'b1;
    od = regs[13][2];
    chk("pin_o", 32'(eo), 32'(pin_o));
    chk("pin_oe", 32'(eoe), 32'(pin_oe_o));
    chk("pullup", 32'(epu), 32'(pullup_o));
    chk("misc", {regs[12][2] ? 4'hF : 4'h0, regs[12][1] ? 4'hF : 4'h0, regs[14][0], !od && lv, !(od && lv)},
      {analog_en_o, so_sel_o, so_pin_o, so_pin_oe_o});
    // Only driven or pulled-up pads have a known level; floating ones are masked out.
    wb(0, PPFC_ADR_PIN_LEVEL, 0, 0);
    chk("level", 32'(eo | epu), rd & 32'(eoe | epu));
  endtask
  initial begin
    logic [3:0]  ra;
    logic [31:0] rv;
    void'($urandom(96849));
    // The second pass resets the block in mid-run, after random traffic has set its registers.
    for (int rp = 0; rp < 2; rp++) begin
      foreach (regs[i]) regs[i] = (i < 6) ? 15 : 0;
      rst_i <= 1;
      repeat (10) @(posedge clk_i);
      rst_i <= 0;
      for (int a = 0; a < 16; a++) wb(0, 4'(a), 0, 0);
      check();
      wb(1, 13, 8, 1);
      wb(1, 12, 2, 1);
      check();
      wb(1, 0, 0, 1);
      wb(1, 13, 0, 1);
      check();
      repeat (300) begin
        so_func <= 1'($urandom);
        ra = 4'($urandom);
        rv = $urandom;
        if (ra == PPFC_ADR_P7_DIR) rv[3] = 1'b0;
        wb(1'($urandom), ra, rv, 4'($urandom));
        check();
      end
    end
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    tally_and_finish();
  end
endmodule
